//--- inc/rdw_pkg.sv
// Constants and carrier types for the receive descriptor write-back block.
// Assumes a 16-bit control memory with 24-bit byte addresses.
package rdw_pkg;
  // Descriptor slot offsets (32-byte slot)
  localparam logic [4:0] OFS_STAT = 5'h00;
  localparam logic [4:0] OFS_CIRC = 5'h02;
  localparam logic [4:0] OFS_IDENT = 5'h04;
  localparam logic [4:0] OFS_BCNT = 5'h06;
  localparam logic [4:0] OFS_SAH = 5'h08;
  localparam logic [4:0] OFS_SAL = 5'h0A;
  localparam logic [4:0] OFS_DMAH = 5'h0C;
  localparam logic [4:0] OFS_DMAL = 5'h0E;
  localparam logic [4:0] OFS_CRCH = 5'h10;
  localparam logic [4:0] OFS_CRCL = 5'h12;
  localparam logic [4:0] OFS_AGE = 5'h14;
  // Status word bit positions
  localparam int B_INPROG = 15;
  localparam int B_LOOKUP = 14;
  localparam int B_SIZE = 12;
  localparam int B_SEQ = 7;
  localparam int B_CONG = 6;
  localparam int B_ENDFLT = 5;
  localparam int B_AGE = 2;
  localparam int B_OVR = 1;
  localparam int B_QUAL = 0;
  // Keeps mode bit 12 only; reserved bits forced low
  localparam logic [15:0] MODE_KEEP = 16'h1000;
  // APB byte offsets
  localparam logic [7:0] A_BASE = 8'h00;
  localparam logic [7:0] A_SLIM = 8'h04;
  localparam logic [7:0] A_LLIM = 8'h08;
  localparam logic [7:0] A_LLEN = 8'h0C;
  localparam logic [7:0] A_CTRL = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [15:0] WORD_BYTES = 16'h0004;
  localparam logic [7:0] AGE_INIT = 8'h00;
  localparam logic [7:0] AGE_MAX = 8'hFF;
  localparam logic [2:0] RD_LAST = 3'h2;
  localparam logic [2:0] WR_LAST = 3'h6;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_READ = 5'h02,
    ST_WRITE = 5'h04,
    ST_RUN = 5'h08,
    ST_PKT = 5'h10
  } rdw_st_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } rdw_cm_t;
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
  } rdw_pm_t;
  typedef struct packed {
    rdw_st_t st;
    logic [5:0] base;
    logic [15:0] slim;
    logic [15:0] llim;
    logic [15:0] llen;
    logic en;
    logic zero_seen;
    logic [12:0] desc;
    logic [15:0] circ;
    logic [15:0] ident;
    logic [15:0] stat;
    logic [31:0] sa;
    logic [31:0] dma;
    logic [31:0] crc;
    logic [15:0] bcnt;
    logic [15:0] used;
    logic [15:0] limit;
    logic [7:0] age;
    logic [2:0] idx;
    logic fin;
    rdw_cm_t cm;
    rdw_pm_t pm;
    logic start_rdy;
    logic cell_rdy;
    logic done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rdw_state_t;
endpackage : rdw_pkg

//--- logic/rdw_engine.sv
// Receive descriptor handling: slot addressing, setup reads, packet
// word stores and final status write-back, with an APB register slave.
// Assumes cell events come from logic on MCLK_IN and memories ack once.
//
// Overview of operation
// R1 - One fixed 32-byte slot per descriptor
// R2 - Base gives six upper address bits only
// R3 - Descriptor numbers 1 to 8191 select slots
// R4 - Host never uses descriptor number zero
// R5 - Write circuit/ident, read start, update fields
// R6 - In-progress bit high, cleared before hand-back
// R7 - Host never writes the in-progress bit
// R8 - Bit 14 records lookup type
// R9 - Host bit 12 picks small or large
// R10 - Limits come from three size registers
// R11 - Bits 13 and 11:8 stay unused
// R12 - Bit 7 flags broken sequence at start
// R13 - Bit 6 flags congestion in any cell
// R14 - Bit 5 meaning follows qualifier bit
// R15 - Missing last cell: terminate, end error
// R16 - Flushed cell: terminate, flushed flag
// R17 - Store parameters and data per descriptor
// R18 - Bit 0 set on cell-level errors
// R19 - 8-bit age counter, overflow terminates
// R20 - DMA address from start, points past end
// R21 - Byte count counts down, finds overflow
// R22 - Final status in one single write
// R23 - Slot offsets 18H-1EH never touched
`timescale 1ns/100ps
`default_nettype none
module rdw_engine (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [31:0] PRDATA_OUT,
  input wire logic START_IN,
  input wire logic [12:0] START_DESC_IN,
  input wire logic [15:0] START_CIRC_IN,
  input wire logic [15:0] START_IDENT_IN,
  input wire logic START_LOOKUP_IN,
  input wire logic [3:0] START_SEQ_IN,
  input wire logic [3:0] START_PREV_SEQ_IN,
  output logic START_READY_OUT,
  input wire logic CELL_VALID_IN,
  input wire logic [31:0] CELL_DATA_IN,
  input wire logic CELL_CONG_IN,
  input wire logic CELL_LAST_IN,
  input wire logic [31:0] CELL_CRC_IN,
  output logic CELL_READY_OUT,
  input wire logic FLUSH_IN,
  input wire logic EOP_MISS_IN,
  input wire logic AGE_TICK_IN,
  output logic CM_REQ_OUT,
  output logic CM_WE_OUT,
  output logic [23:0] CM_ADDR_OUT,
  output logic [15:0] CM_WDATA_OUT,
  input wire logic CM_ACK_IN,
  input wire logic [15:0] CM_RDATA_IN,
  output logic PM_WE_OUT,
  output logic [31:0] PM_ADDR_OUT,
  output logic [31:0] PM_DATA_OUT,
  input wire logic PM_ACK_IN,
  output logic DONE_OUT,
  output logic [12:0] DONE_DESC_OUT
);

  ////////////////////////////////////////////////////////////////////////
  rdw_pkg::rdw_state_t cur_ff;
  rdw_pkg::rdw_state_t nxt_st;
  logic [4:0] rd_ofs;
  logic [4:0] wr_ofs;
  logic [15:0] wr_data;
  logic apb_hit;
  logic terminate;
  logic [15:0] err_bits;

  // Setup reads: mode word, then start address high and low
  always_comb begin
    case (cur_ff.idx)
      3'h0: rd_ofs = rdw_pkg::OFS_STAT;
      3'h1: rd_ofs = rdw_pkg::OFS_SAH; // R5
      default: rd_ofs = rdw_pkg::OFS_SAL; // R5
    endcase
  end

  // Write lists; status goes first on open, last on close
  always_comb begin
    case ({cur_ff.fin, cur_ff.idx})
      4'h0: begin
        wr_ofs = rdw_pkg::OFS_STAT;
        wr_data = cur_ff.stat; // R6
      end
      4'h1: begin
        wr_ofs = rdw_pkg::OFS_CIRC;
        wr_data = cur_ff.circ; // R5
      end
      4'h2: begin
        wr_ofs = rdw_pkg::OFS_IDENT;
        wr_data = cur_ff.ident; // R5
      end
      4'h3, 4'h8: begin
        wr_ofs = rdw_pkg::OFS_BCNT;
        wr_data = cur_ff.bcnt; // R21
      end
      4'h4, 4'h9: begin
        wr_ofs = rdw_pkg::OFS_DMAH;
        wr_data = cur_ff.dma[31:16]; // R20
      end
      4'h5, 4'hA: begin
        wr_ofs = rdw_pkg::OFS_DMAL;
        wr_data = cur_ff.dma[15:0]; // R20
      end
      4'hB: begin
        wr_ofs = rdw_pkg::OFS_CRCH;
        wr_data = cur_ff.crc[31:16];
      end
      4'hC: begin
        wr_ofs = rdw_pkg::OFS_CRCL;
        wr_data = cur_ff.crc[15:0];
      end
      4'h6, 4'hD: begin
        wr_ofs = rdw_pkg::OFS_AGE;
        wr_data = {8'h00, cur_ff.age}; // R19
      end
      default: begin
        wr_ofs = rdw_pkg::OFS_STAT;
        // Errors and cleared flag land together
        wr_data = cur_ff.stat & ~(16'h0001 << rdw_pkg::B_INPROG); // R6 R22
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Termination causes, highest priority first
  always_comb begin
    terminate = 1'b1;
    err_bits = 16'h0000;
    if (FLUSH_IN) begin
      // Cell error: qualifier set, bit 5 reads as flushed
      err_bits = (16'h0001 << rdw_pkg::B_ENDFLT) | (16'h0001 << rdw_pkg::B_QUAL); // R14 R16 R18
    end else if (EOP_MISS_IN) begin
      err_bits = 16'h0001 << rdw_pkg::B_ENDFLT; // R14 R15
    end else if (AGE_TICK_IN && cur_ff.age == rdw_pkg::AGE_MAX) begin
      err_bits = 16'h0001 << rdw_pkg::B_AGE; // R19
    end else if (CELL_VALID_IN && cur_ff.cell_rdy &&
                 (cur_ff.bcnt < rdw_pkg::WORD_BYTES ||
                  cur_ff.used > cur_ff.limit - rdw_pkg::WORD_BYTES)) begin
      // Word would not fit: dropped, packet closed
      err_bits = 16'h0001 << rdw_pkg::B_OVR; // R21
    end else begin
      terminate = 1'b0;
    end
  end

  assign apb_hit = PSEL_IN && PENABLE_IN && !cur_ff.pready;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.done = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    // APB: one wait state so read data comes from a flop
    if (apb_hit) begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
      case (PADDR_IN)
        rdw_pkg::A_BASE: nxt_st.prdata = {26'h0, cur_ff.base};
        rdw_pkg::A_SLIM: nxt_st.prdata = {16'h0, cur_ff.slim};
        rdw_pkg::A_LLIM: nxt_st.prdata = {16'h0, cur_ff.llim};
        rdw_pkg::A_LLEN: nxt_st.prdata = {16'h0, cur_ff.llen};
        rdw_pkg::A_CTRL: nxt_st.prdata = {31'h0, cur_ff.en};
        rdw_pkg::A_STAT: begin
          nxt_st.prdata = {3'h0, cur_ff.desc, 14'h0, cur_ff.zero_seen, cur_ff.st[0]};
        end
        default: nxt_st.pslverr = 1'b1;
      endcase
    end
    if (PSEL_IN && PENABLE_IN && cur_ff.pready && PWRITE_IN) begin
      case (PADDR_IN)
        rdw_pkg::A_BASE: nxt_st.base = PWDATA_IN[5:0]; // R2
        rdw_pkg::A_SLIM: nxt_st.slim = PWDATA_IN[15:0]; // R10
        rdw_pkg::A_LLIM: nxt_st.llim = PWDATA_IN[15:0]; // R10
        rdw_pkg::A_LLEN: nxt_st.llen = PWDATA_IN[15:0]; // R10
        rdw_pkg::A_CTRL: nxt_st.en = PWDATA_IN[0];
        rdw_pkg::A_STAT: begin
          if (PWDATA_IN[1]) begin
            nxt_st.zero_seen = 1'b0;
          end
        end
        default: nxt_st.en = cur_ff.en;
      endcase
    end
    nxt_st.pm.we = cur_ff.pm.we && !PM_ACK_IN;
    case (cur_ff.st)
      rdw_pkg::ST_IDLE: begin
        if (START_IN && cur_ff.start_rdy) begin
          if (START_DESC_IN == 13'h0000) begin
            // Slot zero left alone; set wins over clear
            nxt_st.zero_seen = 1'b1; // R3 R4
          end else begin
            nxt_st.desc = START_DESC_IN; // R3
            nxt_st.circ = START_CIRC_IN;
            nxt_st.ident = START_IDENT_IN;
            nxt_st.stat = 16'h0000;
            nxt_st.stat[rdw_pkg::B_INPROG] = 1'b1; // R6
            nxt_st.stat[rdw_pkg::B_LOOKUP] = START_LOOKUP_IN; // R8
            nxt_st.stat[rdw_pkg::B_SEQ] = (START_SEQ_IN != START_PREV_SEQ_IN + 4'h1); // R12
            nxt_st.age = rdw_pkg::AGE_INIT; // R19
            nxt_st.used = 16'h0000;
            nxt_st.crc = 32'h0000_0000;
            nxt_st.idx = 3'h0;
            nxt_st.fin = 1'b0;
            nxt_st.st = rdw_pkg::ST_READ;
          end
        end
      end
      rdw_pkg::ST_READ: begin
        if (!cur_ff.cm.req) begin
          nxt_st.cm.req = 1'b1;
          nxt_st.cm.we = 1'b0;
          nxt_st.cm.addr = {cur_ff.base, cur_ff.desc, rd_ofs}; // R1 R2 R23
        end else if (CM_ACK_IN) begin
          nxt_st.cm.req = 1'b0;
          nxt_st.idx = cur_ff.idx + 3'h1;
          case (cur_ff.idx)
            3'h0: begin
              // Only the host size bit survives; reserved bits held low
              nxt_st.stat = cur_ff.stat | (CM_RDATA_IN & rdw_pkg::MODE_KEEP); // R9 R11
              nxt_st.bcnt = CM_RDATA_IN[rdw_pkg::B_SIZE] ? cur_ff.llen : cur_ff.slim; // R9 R10 R21
              nxt_st.limit = CM_RDATA_IN[rdw_pkg::B_SIZE] ? cur_ff.llim : cur_ff.slim; // R10
            end
            3'h1: nxt_st.sa[31:16] = CM_RDATA_IN;
            default: begin
              nxt_st.sa[15:0] = CM_RDATA_IN;
              nxt_st.dma = {cur_ff.sa[31:16], CM_RDATA_IN}; // R20
            end
          endcase
          if (cur_ff.idx == rdw_pkg::RD_LAST) begin
            nxt_st.idx = 3'h0;
            nxt_st.st = rdw_pkg::ST_WRITE;
          end
        end
      end
      rdw_pkg::ST_WRITE: begin
        if (!cur_ff.cm.req) begin
          nxt_st.cm.req = 1'b1;
          nxt_st.cm.we = 1'b1;
          nxt_st.cm.addr = {cur_ff.base, cur_ff.desc, wr_ofs}; // R1 R2 R17 R23
          nxt_st.cm.wdata = wr_data; // R5 R17
        end else if (CM_ACK_IN) begin
          nxt_st.cm.req = 1'b0;
          nxt_st.idx = cur_ff.idx + 3'h1;
          if (cur_ff.idx == rdw_pkg::WR_LAST) begin
            nxt_st.idx = 3'h0;
            nxt_st.st = cur_ff.fin ? rdw_pkg::ST_IDLE : rdw_pkg::ST_RUN;
            nxt_st.done = cur_ff.fin;
          end
        end
      end
      rdw_pkg::ST_RUN: begin
        if (AGE_TICK_IN) begin
          nxt_st.age = cur_ff.age + 8'h01; // R19
        end
        if (CELL_VALID_IN && CELL_CONG_IN) begin
          nxt_st.stat[rdw_pkg::B_CONG] = 1'b1; // R13
        end
        if (terminate) begin
          nxt_st.stat = nxt_st.stat | err_bits;
          nxt_st.fin = 1'b1;
          nxt_st.st = rdw_pkg::ST_WRITE;
        end else if (CELL_VALID_IN) begin
          nxt_st.pm.we = 1'b1;
          nxt_st.pm.addr = cur_ff.dma; // R17 R20
          nxt_st.pm.data = CELL_DATA_IN;
          nxt_st.fin = CELL_LAST_IN;
          nxt_st.crc = CELL_CRC_IN;
          nxt_st.st = rdw_pkg::ST_PKT;
        end
      end
      rdw_pkg::ST_PKT: begin
        if (PM_ACK_IN) begin
          nxt_st.dma = cur_ff.dma + 32'h0000_0001; // R20
          nxt_st.bcnt = cur_ff.bcnt - rdw_pkg::WORD_BYTES; // R21
          nxt_st.used = cur_ff.used + rdw_pkg::WORD_BYTES;
          nxt_st.st = cur_ff.fin ? rdw_pkg::ST_WRITE : rdw_pkg::ST_RUN;
        end
      end
      default: nxt_st.st = rdw_pkg::ST_IDLE;
    endcase
    nxt_st.start_rdy = (nxt_st.st == rdw_pkg::ST_IDLE) && nxt_st.en;
    nxt_st.cell_rdy = (nxt_st.st == rdw_pkg::ST_RUN);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      cur_ff <= '0;
      cur_ff.st <= rdw_pkg::ST_IDLE;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign PREADY_OUT = cur_ff.pready;
  assign PSLVERR_OUT = cur_ff.pslverr;
  assign PRDATA_OUT = cur_ff.prdata;
  assign START_READY_OUT = cur_ff.start_rdy;
  assign CELL_READY_OUT = cur_ff.cell_rdy;
  assign CM_REQ_OUT = cur_ff.cm.req;
  assign CM_WE_OUT = cur_ff.cm.we;
  assign CM_ADDR_OUT = cur_ff.cm.addr;
  assign CM_WDATA_OUT = cur_ff.cm.wdata;
  assign PM_WE_OUT = cur_ff.pm.we;
  assign PM_ADDR_OUT = cur_ff.pm.addr;
  assign PM_DATA_OUT = cur_ff.pm.data;
  assign DONE_OUT = cur_ff.done;
  assign DONE_DESC_OUT = cur_ff.desc;

endmodule : rdw_engine
`default_nettype wire

//--- tb/rdw_engine_assertions.sv
// Concurrent checks on the engine's control memory side.
// Bound into every rdw_engine instance; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module rdw_engine_chk (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic START_IN,
  input wire logic [12:0] START_DESC_IN,
  input wire logic START_READY_OUT,
  input wire logic CM_REQ_OUT,
  input wire logic CM_WE_OUT,
  input wire logic [23:0] CM_ADDR_OUT,
  input wire logic [15:0] CM_WDATA_OUT,
  input wire logic CM_ACK_IN,
  input wire logic DONE_OUT,
  input wire logic [12:0] DONE_DESC_OUT
);
  logic [12:0] desc_q;
  logic [20:0] last_q;
  ////////////////////////////////////////
  // Opened slot, and data plus offset of the last acked access
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      desc_q <= 13'h0000;
      last_q <= 21'h00000;
    end else begin
      if (START_IN && START_READY_OUT && START_DESC_IN != 13'h0000) desc_q <= START_DESC_IN;
      if (CM_REQ_OUT && CM_ACK_IN) last_q <= {CM_WDATA_OUT, CM_ADDR_OUT[4:0]};
    end
  end
  default clocking dc @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////
  slot_nonzero_a: assert property (CM_REQ_OUT |-> CM_ADDR_OUT[17:5] != 13'h0000)
    else $error("slot zero accessed");
  slot_index_a: assert property (CM_REQ_OUT |-> CM_ADDR_OUT[17:5] == desc_q)
    else $error("slot index wrong");
  unused_ofs_a: assert property (CM_REQ_OUT |-> CM_ADDR_OUT[4:0] < 5'h18)
    else $error("unused offset touched");
  open_read_a: assert property (START_IN && START_READY_OUT && START_DESC_IN != 13'h0000 |=>
    !START_READY_OUT ##1 (CM_REQ_OUT && !CM_WE_OUT && CM_ADDR_OUT[4:0] == 5'h00 && !START_READY_OUT))
    else $error("open did not read status");
  stat_resv_a: assert property (CM_REQ_OUT && CM_WE_OUT && CM_ADDR_OUT[4:0] == 5'h00 |->
    CM_WDATA_OUT[13] == 1'h0 && CM_WDATA_OUT[11:8] == 4'h0) else $error("reserved bit set");
  close_stat_a: assert property (DONE_OUT |-> last_q[4:0] == 5'h00 && !last_q[20])
    else $error("done without final status");
  done_desc_a: assert property (DONE_OUT |-> DONE_DESC_OUT == desc_q)
    else $error("done names wrong slot");
  req_hold_a: assert property (CM_REQ_OUT && !CM_ACK_IN |=> CM_REQ_OUT && $stable(CM_ADDR_OUT))
    else $error("request dropped early");
endmodule : rdw_engine_chk
bind rdw_engine rdw_engine_chk u_chk (.*);
`default_nettype wire

//--- tb/rdw_engine_tb.sv
// Bench: registers, packet store, terminations of one engine.
// Assumes the host model stands in for shared memory.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("MISMATCH %s %h %h", n, e, g); \
  end \
end
module rdw_engine_tb;
  logic MCLK_IN = '0, RST_IN = '1, PSEL_IN = '0, PENABLE_IN = '0, PWRITE_IN = '0;
  logic START_IN = '0, START_LOOKUP_IN = '0, CELL_VALID_IN = '0, CELL_CONG_IN = '0;
  logic CELL_LAST_IN = '0, FLUSH_IN = '0, EOP_MISS_IN = '0, AGE_TICK_IN = '0, slow = '0;
  logic [7:0] PADDR_IN = '0;
  logic [31:0] PWDATA_IN = '0, CELL_DATA_IN = '0, CELL_CRC_IN = '0, rd;
  logic [12:0] START_DESC_IN = '0, DONE_DESC_OUT;
  logic [15:0] START_CIRC_IN = '0, START_IDENT_IN = '0, CM_WDATA_OUT, CM_RDATA_IN;
  logic [3:0] START_SEQ_IN = '0, START_PREV_SEQ_IN = '0;
  logic PREADY_OUT, PSLVERR_OUT, START_READY_OUT, CELL_READY_OUT, CM_REQ_OUT, CM_WE_OUT;
  logic CM_ACK_IN, PM_WE_OUT, PM_ACK_IN, DONE_OUT, err;
  logic [31:0] PRDATA_OUT, PM_ADDR_OUT, PM_DATA_OUT;
  logic [23:0] CM_ADDR_OUT;
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #2 MCLK_IN = ~MCLK_IN;
  rdw_engine DUT (.*);
  rdw_host_mdl MDL (.clk_in(MCLK_IN), .rst_in(RST_IN), .slow_in(slow), .cm_req_in(CM_REQ_OUT),
    .cm_we_in(CM_WE_OUT), .cm_addr_in(CM_ADDR_OUT), .cm_wdata_in(CM_WDATA_OUT),
    .cm_ack_out(CM_ACK_IN), .cm_rdata_out(CM_RDATA_IN), .pm_we_in(PM_WE_OUT), .pm_ack_out(PM_ACK_IN));
  always @(posedge MCLK_IN) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL_IN <= 1'h1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge MCLK_IN);
    PENABLE_IN <= 1'h1;
    do @(posedge MCLK_IN); while (PREADY_OUT !== 1'h1);
    rd = PRDATA_OUT;
    err = PSLVERR_OUT;
    PSEL_IN <= 1'h0;
    PENABLE_IN <= 1'h0;
    @(posedge MCLK_IN);
  endtask : apb
  task automatic wait_run();
    do @(posedge MCLK_IN); while (CELL_READY_OUT !== 1'h1);
  endtask : wait_run
  task automatic open_pkt(input logic [12:0] n, input logic [15:0] mode, input logic lk, input logic [3:0] sq);
    MDL.mem[0] = mode;
    MDL.mem[4] = 16'h0001;
    MDL.mem[5] = 16'h2000;
    START_IN <= 1'h1;
    START_DESC_IN <= n;
    START_CIRC_IN <= {3'h0, n};
    START_IDENT_IN <= ~{3'h0, n};
    START_LOOKUP_IN <= lk;
    START_SEQ_IN <= sq;
    START_PREV_SEQ_IN <= 4'h3;
    do @(posedge MCLK_IN); while (START_READY_OUT !== 1'h1);
    START_IN <= 1'h0;
    wait_run();
    `CHK("busy", 1'h1, MDL.mem[0][15])
    `CHK("base", 6'h25, MDL.base_seen)
  endtask : open_pkt
  task automatic put_word(input logic [31:0] d, input logic cg, input logic lst, input logic [31:0] pa);
    CELL_VALID_IN <= 1'h1;
    CELL_DATA_IN <= d;
    CELL_CONG_IN <= cg;
    CELL_LAST_IN <= lst;
    do @(posedge MCLK_IN); while (CELL_READY_OUT !== 1'h1);
    CELL_VALID_IN <= 1'h0;
    // All ones marks a word that must be dropped
    if (pa !== 32'hFFFFFFFF) begin
      do @(posedge MCLK_IN); while (PM_WE_OUT !== 1'h1);
      `CHK("pm addr", pa, PM_ADDR_OUT)
      `CHK("pm data", d, PM_DATA_OUT)
      if (!lst) wait_run();
    end
  endtask : put_word
  task automatic close_chk(input logic [12:0] n, input logic [15:0] st, input logic [15:0] bc);
    do @(posedge MCLK_IN); while (DONE_OUT !== 1'h1);
    `CHK("done desc", n, DONE_DESC_OUT)
    `CHK("status", st, MDL.mem[0])
    `CHK("bytes", bc, MDL.mem[3])
    `CHK("ids", {3'h0, n, ~{3'h0, n}}, {MDL.mem[1], MDL.mem[2]})
  endtask : close_chk
  ////////////////////////////////////////
  task automatic t_regs();
    apb(1'h0, rdw_pkg::A_STAT, 32'h0);
    `CHK("stat rst", 32'h00000001, rd)
    apb(1'h1, rdw_pkg::A_BASE, 32'hFFFFFFE5);
    apb(1'h0, rdw_pkg::A_BASE, 32'h0);
    `CHK("base reg", 32'h00000025, rd)
    apb(1'h0, 8'h40, 32'h0);
    `CHK("unmapped", 1'h1, err)
    apb(1'h1, rdw_pkg::A_SLIM, 32'h00000040);
    apb(1'h1, rdw_pkg::A_LLIM, 32'h00000200);
    apb(1'h1, rdw_pkg::A_LLEN, 32'h00000100);
    apb(1'h1, rdw_pkg::A_CTRL, 32'h00000001);
    $display("regs done");
  endtask : t_regs
  task automatic t_small();
    open_pkt(13'h0011, 16'h2F00, 1'h1, 4'h5);
    put_word(32'hA5A50001, 1'h0, 1'h0, 32'h00012000);
    put_word(32'hA5A50002, 1'h1, 1'h1, 32'h00012001);
    close_chk(13'h0011, 16'h40C0, 16'h0038);
    `CHK("dma", 32'h00012002, {MDL.mem[6], MDL.mem[7]})
    $display("small done");
  endtask : t_small
  task automatic t_flush();
    slow <= 1'h1;
    open_pkt(13'h1FFF, 16'h1000, 1'h0, 4'h4);
    put_word(32'h0000BEEF, 1'h0, 1'h0, 32'h00012000);
    FLUSH_IN <= 1'h1;
    @(posedge MCLK_IN);
    FLUSH_IN <= 1'h0;
    close_chk(13'h1FFF, 16'h1021, 16'h00FC);
    slow <= 1'h0;
    $display("flush done");
  endtask : t_flush
  task automatic t_age();
    open_pkt(13'h0002, 16'h0000, 1'h0, 4'h4);
    for (int i = 0; i < 256; i++) begin
      if (i == 255) `CHK("age run", 1'h1, CELL_READY_OUT)
      AGE_TICK_IN <= 1'h1;
      @(posedge MCLK_IN);
      AGE_TICK_IN <= 1'h0;
      @(posedge MCLK_IN);
    end
    close_chk(13'h0002, 16'h0004, 16'h0040);
    $display("age done");
  endtask : t_age
  task automatic t_ovf();
    apb(1'h1, rdw_pkg::A_SLIM, 32'h00000004);
    open_pkt(13'h0003, 16'h0000, 1'h0, 4'h4);
    put_word(32'h11111111, 1'h0, 1'h0, 32'h00012000);
    put_word(32'h22222222, 1'h0, 1'h0, 32'hFFFFFFFF);
    close_chk(13'h0003, 16'h0002, 16'h0000);
    `CHK("dma ovf", 32'h00012001, {MDL.mem[6], MDL.mem[7]})
    $display("overflow done");
  endtask : t_ovf
  task automatic t_zero();
    START_IN <= 1'h1;
    START_DESC_IN <= 13'h0000;
    do @(posedge MCLK_IN); while (START_READY_OUT !== 1'h1);
    START_IN <= 1'h0;
    apb(1'h0, rdw_pkg::A_STAT, 32'h0);
    `CHK("zero desc", 32'h00030003, rd)
    `CHK("zero idle", 1'h1, START_READY_OUT)
    `CHK("zero cm", 1'h0, CM_REQ_OUT)
    apb(1'h1, rdw_pkg::A_STAT, 32'h00000002);
    apb(1'h0, rdw_pkg::A_STAT, 32'h0);
    `CHK("zero clr", 32'h00030001, rd)
    $display("zero done");
  endtask : t_zero
  task automatic t_eop();
    open_pkt(13'h0004, 16'h1000, 1'h0, 4'h4);
    CELL_CRC_IN <= 32'h89ABCDEF;
    put_word(32'h0000CAFE, 1'h0, 1'h0, 32'h00012000);
    EOP_MISS_IN <= 1'h1;
    @(posedge MCLK_IN);
    EOP_MISS_IN <= 1'h0;
    close_chk(13'h0004, 16'h1020, 16'h00FC);
    `CHK("crc", 32'h89ABCDEF, {MDL.mem[8], MDL.mem[9]})
    $display("eop done");
  endtask : t_eop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(posedge MCLK_IN);
    RST_IN <= 1'h0;
    @(posedge MCLK_IN);
    t_regs();
    t_small();
    t_flush();
    t_age();
    t_ovf();
    t_zero();
    t_eop();
    end_of_test();
  end
endmodule : rdw_engine_tb
`default_nettype wire

//--- tb/rdw_host_mdl.sv
// Host side: one descriptor slot of control memory, packet memory acks.
// Assumes one open descriptor at a time; slow mode adds wait cycles.
`timescale 1ns/100ps
`default_nettype none
module rdw_host_mdl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic cm_req_in,
  input wire logic cm_we_in,
  input wire logic [23:0] cm_addr_in,
  input wire logic [15:0] cm_wdata_in,
  input wire logic pm_we_in,
  output logic cm_ack_out,
  output logic [15:0] cm_rdata_out,
  output logic pm_ack_out
);
  logic [15:0] mem [16];
  logic [5:0] base_seen;
  logic [1:0] dly;
  always @(posedge clk_in) begin
    if (rst_in) begin
      cm_ack_out <= 1'h0;
      pm_ack_out <= 1'h0;
      cm_rdata_out <= 16'h0000;
      dly <= 2'h0;
    end else begin
      pm_ack_out <= pm_we_in && !pm_ack_out;
      dly <= (cm_req_in && !cm_ack_out) ? dly + 2'h1 : 2'h0;
      if (cm_req_in && !cm_ack_out && (!slow_in || dly == 2'h3)) begin
        cm_ack_out <= 1'h1;
        cm_rdata_out <= mem[cm_addr_in[4:1]];
        base_seen <= cm_addr_in[23:18];
        // Only the device writes; host leaves the busy flag alone
        if (cm_we_in) mem[cm_addr_in[4:1]] <= cm_wdata_in;
      end else begin
        // Idle bus never keeps its last value
        cm_ack_out <= 1'h0;
        cm_rdata_out <= ~cm_rdata_out;
      end
    end
  end
endmodule : rdw_host_mdl
`default_nettype wire
